// >>> common/wsa_params.svh
// constants for the work-station adapter latch block
// assumes inclusion by the package and the logic file only
`ifndef WSA_PARAMS_SVH
`define WSA_PARAMS_SVH
`define WSA_ADDR_W 16
`define WSA_MAX_ADDR 16'hffff
`define WSA_OVF_BIT 2
`define WSA_PTR_W 8
`define WSA_PTR_N 8
`define WSA_PTR_IDX_W 3
// sense byte 1 (host side latches)
`define WSA_S1_DIAG 0
`define WSA_S1_XFER 1
`define WSA_S1_IRQEN 2
`define WSA_S1_SREQ 3
`define WSA_S1_CMDP 4
// sense byte 2 (controller side latches)
`define WSA_S2_OPCHK 0
`define WSA_S2_BUSY 1
`define WSA_S2_PAR 2
`define WSA_S2_IRQ 3
// sense byte 3 (selection and address state)
`define WSA_S3_PRIMARY 0
`define WSA_S3_OVF 1
`endif

// >>> common/wsa_pkg.sv
// types for the work-station adapter latch block
// assumes wsa_params.svh on the include path
`include "wsa_params.svh"
package wsa_pkg;
  // one set/clear pair per latch; set and clear together means clear
  typedef struct packed {
    logic set;
    logic clr;
  } wsa_sc_s;

  typedef struct packed {
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } wsa_sense_s;

  typedef struct packed {
    logic wr;
    logic [`WSA_PTR_IDX_W-1:0] idx;
    logic [`WSA_PTR_W-1:0] data;
  } wsa_ptr_wr_s;
endpackage

// >>> logic/wsa_latches.sv
// interface latches between host channel and internal controller
// assumes all inputs come from logic on clk; adapter_reset is a synchronous pulse
//
// Function
// - adapter reset zeroes all three sense bytes
// - host sets/clears diagnostic mode, reported, reset clears
// - host sets/clears transfer error latch, held, reset clears
// - host enables/disables interrupt; disabled presents none
// - host sets/resets service request; held; reset clears
// - host sets/resets command pending; reset clears
// - controller senses and resets command pending
// - address bit 1 of sense byte 3 set when a step reaches maximum address; held until cleared
// - controller sets/resets operation check; host senses
// - no-check jump condition false while check set
// - controller sets/clears busy; host senses it
// - controller sets/resets parity check; host senses
// - controller interrupts when enabled; host clears request
// - controller senses and resets service required
// - controller senses/resets transfer check, reports status
// - pointer registers individually selectable and independent
// - pointer registers hold 5 and a patterns
// - select command switches primary/auxiliary, readable
// - primary sense on after reset, tracks select
`timescale 1ns/1ps
`include "wsa_params.svh"
module wsa_latches #(
  parameter int ADDR_W = `WSA_ADDR_W,
  parameter int PTR_W = `WSA_PTR_W,
  parameter int PTR_N = `WSA_PTR_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic adapter_reset,
  // host channel latch commands
  input wire wsa_pkg::wsa_sc_s host_diag,
  input wire wsa_pkg::wsa_sc_s host_xfer,
  input wire wsa_pkg::wsa_sc_s host_irq_en,
  input wire wsa_pkg::wsa_sc_s host_sreq,
  input wire wsa_pkg::wsa_sc_s host_cmdp,
  input wire logic host_irq_clr,
  // controller latch commands
  input wire wsa_pkg::wsa_sc_s ctl_opchk,
  input wire wsa_pkg::wsa_sc_s ctl_busy,
  input wire wsa_pkg::wsa_sc_s ctl_par,
  input wire logic ctl_irq_req,
  input wire logic ctl_xfer_clr,
  input wire logic ctl_sreq_clr,
  input wire logic ctl_cmdp_clr,
  // controller memory address
  input wire logic mar_load,
  input wire logic [ADDR_W-1:0] mar_load_value,
  input wire logic mar_step,
  input wire logic ovf_clr,
  // pointer registers and bank select
  input wire wsa_pkg::wsa_ptr_wr_s ptr_wr,
  input wire logic [`WSA_PTR_IDX_W-1:0] ptr_rd_idx,
  input wire logic register_bank_select_command,
  input wire logic bank_select_aux,
  // controller status byte to host
  input wire logic outbound_byte_bus_wr,
  input wire logic [7:0] outbound_byte_bus_in,
  // outputs
  output wsa_pkg::wsa_sense_s sense,
  output logic [ADDR_W-1:0] memory_address_register,
  output logic [PTR_W-1:0] ptr_rd_data,
  output logic jump_on_io_condition,
  output logic host_irq,
  output logic [7:0] outbound_byte_bus,
  output logic primary_selected
);
  // refuse parameter values the logic cannot serve
  if (ADDR_W <= `WSA_OVF_BIT) begin : g_bad_addr_w
    $error("wsa_latches: address register too narrow");
  end
  if (PTR_N > (1 << `WSA_PTR_IDX_W) || PTR_N < 1) begin : g_bad_ptr_n
    $error("wsa_latches: pointer count does not fit the index");
  end
  if (PTR_W < 4) begin : g_bad_ptr_w
    $error("wsa_latches: pointer register too narrow");
  end
  if (PTR_W > `WSA_PTR_W) begin : g_wide_ptr_w
    $error("wsa_latches: pointer register wider than its write data");
  end

  // set/clear latch update; clear wins over set so software can always drop it
  function automatic logic sc_next(input logic cur, input wsa_pkg::wsa_sc_s c, input logic clr2);
    sc_next = (cur | c.set) & ~(c.clr | clr2);
  endfunction

  logic diag, xfer, irq_en, sreq, cmdp, opchk, busy, par, irq_pend, ovf;
  logic [PTR_W-1:0] ptr_bank [2][PTR_N];
  logic bank_aux;

  wire logic next_diag = sc_next(diag, host_diag, 1'b0);
  wire logic next_xfer = sc_next(xfer, host_xfer, ctl_xfer_clr);
  wire logic next_irq_en = sc_next(irq_en, host_irq_en, 1'b0);
  wire logic next_sreq = sc_next(sreq, host_sreq, ctl_sreq_clr);
  wire logic next_cmdp = sc_next(cmdp, host_cmdp, ctl_cmdp_clr);
  wire logic next_opchk = sc_next(opchk, ctl_opchk, 1'b0);
  wire logic next_busy = sc_next(busy, ctl_busy, 1'b0);
  wire logic next_par = sc_next(par, ctl_par, 1'b0);
  // a new request while the host clears keeps the request pending
  wire logic next_irq_pend = irq_en & (ctl_irq_req | (irq_pend & ~host_irq_clr));
  wire logic [ADDR_W-1:0] max_addr = ADDR_W'(`WSA_MAX_ADDR);
  wire logic at_max = (memory_address_register == max_addr);
  wire logic [ADDR_W-1:0] next_mar = mar_load ? mar_load_value :
    (mar_step && !at_max) ? memory_address_register + ADDR_W'(1) : memory_address_register;
  wire logic ovf_event = mar_step && !mar_load && (next_mar == max_addr) && !at_max;
  wire logic next_ovf = ovf_event | (ovf & ~ovf_clr);
  wire logic next_bank_aux = register_bank_select_command ? bank_select_aux : bank_aux;

  // every latch moves on the same edge; adapter reset beats any set from either side
  // diagnostic mode, set and cleared by the host
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      diag <= 1'b0;
    end else if (adapter_reset) begin
      diag <= 1'b0;
    end else begin
      diag <= next_diag;
    end
  end

  // transfer error, set by the host, cleared by either side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer <= 1'b0;
    end else if (adapter_reset) begin
      xfer <= 1'b0;
    end else begin
      xfer <= next_xfer;
    end
  end

  // interrupt enable, owned by the host
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= 1'b0;
    end else if (adapter_reset) begin
      irq_en <= 1'b0;
    end else begin
      irq_en <= next_irq_en;
    end
  end

  // service request, set by the host, cleared by either side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sreq <= 1'b0;
    end else if (adapter_reset) begin
      sreq <= 1'b0;
    end else begin
      sreq <= next_sreq;
    end
  end

  // command pending, set by the host, taken down by the controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdp <= 1'b0;
    end else if (adapter_reset) begin
      cmdp <= 1'b0;
    end else begin
      cmdp <= next_cmdp;
    end
  end

  // operation check, owned by the controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opchk <= 1'b0;
    end else if (adapter_reset) begin
      opchk <= 1'b0;
    end else begin
      opchk <= next_opchk;
    end
  end

  // busy, owned by the controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (adapter_reset) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  // byte bus parity check, owned by the controller
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      par <= 1'b0;
    end else if (adapter_reset) begin
      par <= 1'b0;
    end else begin
      par <= next_par;
    end
  end

  // pending interrupt toward the host
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend <= 1'b0;
    end else if (adapter_reset) begin
      irq_pend <= 1'b0;
    end else begin
      irq_pend <= next_irq_pend;
    end
  end

  // top address indication; reaching the top wins over a clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf <= 1'b0;
    end else if (adapter_reset) begin
      ovf <= 1'b0;
    end else begin
      ovf <= next_ovf;
    end
  end

  // register bank selection; reset returns to the primary bank
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_aux <= 1'b0;
    end else if (adapter_reset) begin
      bank_aux <= 1'b0;
    end else begin
      bank_aux <= next_bank_aux;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_address_register <= '0;
    end else begin
      memory_address_register <= next_mar;
    end
  end

  // pointer registers: one write per cycle into the selected bank only
  for (genvar b = 0; b < 2; b++) begin : g_bank
    for (genvar i = 0; i < PTR_N; i++) begin : g_ptr
      wire logic hit = ptr_wr.wr && (ptr_wr.idx == (`WSA_PTR_IDX_W)'(i)) && (bank_aux == (b == 1));
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ptr_bank[b][i] <= '0;
        end else if (hit) begin
          ptr_bank[b][i] <= PTR_W'(ptr_wr.data);
        end
      end
    end
  end

  wire logic [PTR_W-1:0] ptr_sel = (int'(ptr_rd_idx) < PTR_N) ? ptr_bank[bank_aux][ptr_rd_idx] : '0;

  logic [7:0] next_byte1, next_byte2, next_byte3;

  // host-owned latches in sense byte 1, unused bits read zero
  always_comb begin
    next_byte1 = 8'h00;
    next_byte1[`WSA_S1_DIAG] = diag;
    next_byte1[`WSA_S1_XFER] = xfer;
    next_byte1[`WSA_S1_IRQEN] = irq_en;
    next_byte1[`WSA_S1_SREQ] = sreq;
    next_byte1[`WSA_S1_CMDP] = cmdp;
  end

  // controller-owned latches and the pending interrupt in sense byte 2
  always_comb begin
    next_byte2 = 8'h00;
    next_byte2[`WSA_S2_OPCHK] = opchk;
    next_byte2[`WSA_S2_BUSY] = busy;
    next_byte2[`WSA_S2_PAR] = par;
    next_byte2[`WSA_S2_IRQ] = irq_pend;
  end

  // address indication in sense byte 3; the primary bit has a port of its own
  always_comb begin
    next_byte3 = 8'h00;
    next_byte3[`WSA_S3_OVF] = ovf;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_rd_data <= '0;
      outbound_byte_bus <= 8'h00;
    end else begin
      ptr_rd_data <= ptr_sel;
      if (adapter_reset) begin
        outbound_byte_bus <= 8'h00;
      end else if (outbound_byte_bus_wr) begin
        outbound_byte_bus <= outbound_byte_bus_in;
      end
    end
  end

  // sense bytes read the latches directly so they show zero right after reset
  assign sense.byte1 = next_byte1;
  assign sense.byte2 = next_byte2;
  // primary bit always reads zero in byte 3; sensed separately below
  assign sense.byte3 = next_byte3;
  assign primary_selected = ~bank_aux;
  assign jump_on_io_condition = ~opchk;
  assign host_irq = irq_pend & irq_en;
endmodule // wsa_latches

// >>> tb/wsa_latches_assertions.sv
// assertions for the adapter latch block
// assumes binding onto wsa_latches
`timescale 1ns/1ps
module wsa_latches_checker #(parameter int ADDR_W = 16) (
  // clock, resets and requests
  input wire logic clk,
  input wire logic rst_b,
  input wire logic adapter_reset,
  input wire logic ovf_clr,
  input wire logic ctl_irq_req,
  input wire logic ctl_cmdp_clr,
  input wire wsa_pkg::wsa_sc_s host_irq_en,
  input wire wsa_pkg::wsa_sc_s host_cmdp,
  input wire wsa_pkg::wsa_sc_s ctl_busy,
  // results
  input wire wsa_pkg::wsa_sense_s sense,
  input wire logic [ADDR_W-1:0] memory_address_register,
  input wire logic jump_on_io_condition,
  input wire logic host_irq,
  input wire logic primary_selected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_reset_all: assert property (adapter_reset |=> sense == '0 && primary_selected)
    else $error("adapter reset left state");
  chk_jump_check: assert property (jump_on_io_condition == !sense.byte2[0])
    else $error("jump condition wrong");
  chk_irq_gate: assert property (host_irq |-> sense.byte1[2])
    else $error("interrupt while disabled");
  chk_irq_off_disabled: assert property (!sense.byte1[2] |=> !host_irq)
    else $error("interrupt after disabled cycle");
  chk_irq_raise: assert property (ctl_irq_req && sense.byte1[2] && !host_irq_en.clr && !adapter_reset |=> host_irq)
    else $error("interrupt not raised");
  chk_cmdp_set: assert property (host_cmdp == 2'b10 && !ctl_cmdp_clr && !adapter_reset |=> sense.byte1[4])
    else $error("command pending not set");
  chk_cmdp_clear: assert property (ctl_cmdp_clr && !host_cmdp.set |=> !sense.byte1[4])
    else $error("command pending not cleared");
  chk_busy_set: assert property (ctl_busy == 2'b10 && !adapter_reset |=> sense.byte2[1])
    else $error("busy not set");
  chk_ovf_max: assert property ($rose(sense.byte3[1]) |-> memory_address_register == '1)
    else $error("overflow before top address");
  chk_ovf_sticky: assert property (sense.byte3[1] && !ovf_clr && !adapter_reset |=> sense.byte3[1])
    else $error("overflow dropped");
endmodule // wsa_latches_checker
bind wsa_latches wsa_latches_checker #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst_b, .adapter_reset, .ovf_clr, .ctl_irq_req,
  .ctl_cmdp_clr, .host_irq_en, .host_cmdp, .ctl_busy, .sense, .memory_address_register, .jump_on_io_condition,
  .host_irq, .primary_selected);

// >>> tb/wsa_ctl_model.sv
// controller model: clears a pending host command and reports status
// assumes sense byte 1 of the latch block on its input
`timescale 1ns/1ps
module wsa_ctl_model #(parameter int DLY = 2) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // latch state in, answers out
  input wire logic [7:0] status_byte,
  output logic cmdp_clr,
  output logic status_wr,
  output logic [7:0] status_out
);
  int cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      {cmdp_clr, status_wr, status_out} <= '0;
    end else begin
      {cmdp_clr, status_wr} <= 2'b00;
      cnt <= (status_byte[4] && !cmdp_clr && cnt != DLY) ? cnt + 1 : 0;
      if (status_byte[4] && !cmdp_clr && cnt == DLY)
        {cmdp_clr, status_wr, status_out} <= {2'b11, status_byte};
    end
  end
endmodule // wsa_ctl_model

// >>> tb/tb_wsa_latches.sv
// bench for the adapter latch block
// assumes the package compiled first
`timescale 1ns/1ps
module tb_wsa_latches;
  logic clk, rst_b, adapter_reset, host_irq_clr, ctl_irq_req, ctl_cmdp_clr, mar_load, mar_step, ovf_clr;
  logic register_bank_select_command, bank_select_aux, outbound_byte_bus_wr, jump_on_io_condition, host_irq;
  logic primary_selected;
  logic [17:0] cmd;
  logic [15:0] mar_load_value, memory_address_register;
  logic [7:0] outbound_byte_bus_in, outbound_byte_bus, ptr_rd_data, d;
  logic [2:0] ptr_rd_idx;
  logic [33:0] rows [7] = '{{18'h000aa, 16'h0f00}, {18'h30000, 16'h0500}, {18'h00055, 16'h0000},
    {18'h0a800, 16'h0007}, {18'h05400, 16'h0000}, {18'h0ffff, 16'h0000}, {18'h0000a, 16'h0300}};
  wsa_pkg::wsa_ptr_wr_s ptr_wr;
  wsa_pkg::wsa_sense_s sense;
  int bad_count, tests_run, cyc;
  wsa_latches u_dut (.clk, .rst_b, .adapter_reset, .host_diag(cmd[1:0]), .host_xfer(cmd[3:2]),
    .host_irq_en(cmd[5:4]), .host_sreq(cmd[7:6]), .host_cmdp(cmd[9:8]), .host_irq_clr, .ctl_opchk(cmd[11:10]),
    .ctl_busy(cmd[13:12]), .ctl_par(cmd[15:14]), .ctl_irq_req, .ctl_xfer_clr(cmd[16]), .ctl_sreq_clr(cmd[17]),
    .ctl_cmdp_clr, .mar_load, .mar_load_value, .mar_step, .ovf_clr, .ptr_wr, .ptr_rd_idx,
    .register_bank_select_command, .bank_select_aux, .outbound_byte_bus_wr, .outbound_byte_bus_in, .sense,
    .memory_address_register, .ptr_rd_data, .jump_on_io_condition, .host_irq, .outbound_byte_bus, .primary_selected);
  wsa_ctl_model #(.DLY(2)) u_ctl (.clk, .rst_b, .status_byte(sense.byte1), .cmdp_clr(ctl_cmdp_clr),
    .status_wr(outbound_byte_bus_wr), .status_out(outbound_byte_bus_in));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  // one-cycle pulse of latch commands, then wait for the answer
  task automatic hit(input logic [17:0] c, input logic r, q, a);
    @(posedge clk) {cmd, ctl_irq_req, host_irq_clr, adapter_reset} <= {c, r, q, a};
    @(posedge clk) {cmd, ctl_irq_req, host_irq_clr, adapter_reset} <= '0;
    @(negedge clk);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {clk, rst_b, adapter_reset, host_irq_clr, ctl_irq_req, mar_load, mar_step, ovf_clr} = '0;
    {register_bank_select_command, bank_select_aux, cmd, mar_load_value, ptr_rd_idx, ptr_wr} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset", {sense, primary_selected, jump_on_io_condition}, 26'h3);
    foreach (rows[i]) begin
      hit(rows[i][33:16], 0, 0, 0);
      chk("latches", {sense.byte1, sense.byte2}, rows[i][15:0]);
    end
    hit(18'h00800, 0, 0, 0);
    chk("jump check set", jump_on_io_condition, 0);
    hit(18'h00400, 0, 0, 0);
    chk("jump check clear", jump_on_io_condition, 1);
    hit(18'h000aa, 0, 0, 1);
    chk("adapter reset", sense, 0);
    hit(18'h00020, 0, 0, 0);
    hit('0, 1, 0, 0);
    chk("irq", host_irq, 1);
    hit('0, 0, 1, 0);
    chk("irq clear", host_irq, 0);
    hit(18'h00010, 0, 0, 0);
    hit('0, 1, 0, 0);
    hit(18'h00020, 0, 0, 0);
    chk("irq disabled", host_irq, 0);
    hit(18'h00200, 0, 0, 0);
    chk("cmd pending", sense.byte1[4], 1);
    repeat (4) @(posedge clk);
    @(negedge clk) chk("cmd status", {sense.byte1[4], outbound_byte_bus}, 9'h014);
    @(posedge clk) {mar_load, mar_load_value} <= {1'b1, 16'hfffd};
    @(posedge clk) {mar_load, mar_step} <= 2'b01;
    @(posedge clk);
    @(negedge clk) chk("addr", {sense.byte3[1], memory_address_register}, 17'h0fffe);
    @(posedge clk) mar_step <= 1'b0;
    @(negedge clk) chk("addr top", {sense.byte3[1], memory_address_register}, 17'h1ffff);
    @(posedge clk) ovf_clr <= 1'b1;
    @(posedge clk) ovf_clr <= 1'b0;
    @(negedge clk) chk("ovf clear", sense.byte3[1], 0);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk) {register_bank_select_command, bank_select_aux} <= {1'b1, 1'((p ^ (p >> 1)) & 1)};
      @(posedge clk) register_bank_select_command <= 1'b0;
      @(negedge clk) chk("bank", primary_selected, !bank_select_aux);
      for (int i = 0; i < 8; i++) begin
        d = ((i ^ p ^ (p >> 1)) & 1) ? 8'h55 : 8'haa;
        @(posedge clk) {ptr_wr, ptr_rd_idx} <= {p < 2, 3'(i), d, 3'(i)};
        @(posedge clk) ptr_wr <= '0;
        @(negedge clk) if (p > 1) chk("pointer", ptr_rd_data, d);
      end
    end
    @(posedge clk) {register_bank_select_command, bank_select_aux} <= 2'b11;
    @(posedge clk) register_bank_select_command <= 1'b0;
    hit('0, 0, 0, 1);
    chk("bank reset", primary_selected, 1);
    end_of_test();
  end
endmodule // tb_wsa_latches
